// ### logic/bdmd_pkg.sv
// Shared constants for the banked data memory decoder.
package bdmd_pkg;
   localparam int DW        = 8;   // Data width of every memory location.
   localparam int DM_AW     = 8;   // Full data memory address: bank bit plus file address.
   localparam int FILE_AW   = 7;   // File address carried by an instruction.
   localparam int SLOT_AW   = 5;   // Special function slot index within a bank.
   localparam int SFR_SLOTS = 32;
   localparam int SFR_STORE = 64;  // Both banks of special function slots.
   localparam int GPR_DEPTH = 64;
   localparam int GPR_AW    = 6;

   localparam logic [FILE_AW-1:0] GPR_FIRST  = 7'h20;
   localparam logic [FILE_AW-1:0] GPR_LAST   = 7'h5F;
   localparam logic [FILE_AW-1:0] SFR_LIMIT  = 7'h20;
   localparam logic [FILE_AW-1:0] IND_OFFSET = 7'h00;

   // Register indices; the APB byte address is four times the index.
   localparam logic [DM_AW-1:0] IDX_INDIRECT_PORT   = 8'h00;
   localparam logic [DM_AW-1:0] IDX_INDIRECT_PORT_1 = 8'h80;
   localparam logic [DM_AW-1:0] IDX_CORE_FLAGS_WORD = 8'h03;
   localparam logic [DM_AW-1:0] IDX_FILE_SEL_PTR    = 8'h04;
   localparam int               APB_IDX_LSB         = 2;

   // Fields of the core flags word.
   localparam int FLAGS_BANK_SELECT   = 5;
   localparam int FLAGS_UPPER_BANK    = 6;
   localparam int FLAGS_INDIRECT_BANK = 7;

   localparam logic [DW-1:0] FLAGS_RESET = 8'h18;
   localparam logic [DW-1:0] SFR_RESET   = 8'h00;
   localparam logic [DW-1:0] READ_ZERO   = 8'h00;

   // Implemented special function slots per bank, and slots mirrored into both banks.
   localparam logic [SFR_SLOTS-1:0] SFR_IMPL_BANK0 = 32'hC201_DCBE;
   localparam logic [SFR_SLOTS-1:0] SFR_IMPL_BANK1 = 32'hFE63_5CBE;
   localparam logic [SFR_SLOTS-1:0] SFR_SHARED     = 32'h0000_0C1C;
endpackage

// ### logic/bdmd_gpr_ram.sv
// General purpose static RAM shared by both banks.
`timescale 1ns/1ps
module bdmd_gpr_ram #(
   parameter int DEPTH = bdmd_pkg::GPR_DEPTH,
   parameter int AW    = bdmd_pkg::GPR_AW
) (
   input  wire logic                  pclk,   // Core clock.
   input  wire logic                  we,     // Write strobe.
   input  wire logic [AW-1:0]         addr,   // Entry index.
   input  wire logic [bdmd_pkg::DW-1:0] wdata, // Write data.
   output logic      [bdmd_pkg::DW-1:0] rdata  // Read data, combinational.
);
   import bdmd_pkg::*;

   // Plain static RAM: contents survive reset and are undefined at power-up.
   logic [DW-1:0] mem [0:DEPTH-1];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];
endmodule

// ### logic/bdmd_sfr_store.sv
// Special function register slots of both banks, with mirrored and absent slots.
`timescale 1ns/1ps
module bdmd_sfr_store (
   input  wire logic                       pclk,     // Core clock.
   input  wire logic                       presetn,  // Asynchronous reset, active low.
   input  wire logic                       we,       // Write strobe for a slot access.
   input  wire logic                       bank,     // Bank of the slot.
   input  wire logic [bdmd_pkg::SLOT_AW-1:0] slot,   // Slot within the bank.
   input  wire logic [bdmd_pkg::DW-1:0]    wdata,    // Write data.
   output logic      [bdmd_pkg::DW-1:0]    rdata,    // Read data, zero for absent slots.
   output logic                            present,  // Slot is implemented.
   output logic      [bdmd_pkg::DW-1:0]    flags,    // Core flags word.
   output logic      [bdmd_pkg::DW-1:0]    fsp       // File select pointer.
);
   import bdmd_pkg::*;

   logic [DW-1:0]        mem_q [0:SFR_STORE-1];
   logic [SLOT_AW:0]     index;
   logic [SFR_SLOTS-1:0] impl_mask;

   // Mirrored slots always land in the bank 0 copy so both banks see one value.
   assign index     = {bank & ~SFR_SHARED[slot], slot};
   assign impl_mask = bank ? SFR_IMPL_BANK1 : SFR_IMPL_BANK0;
   assign present   = impl_mask[slot];
   assign rdata     = present ? mem_q[index] : READ_ZERO;
   assign flags     = mem_q[IDX_CORE_FLAGS_WORD[SLOT_AW:0]];
   assign fsp       = mem_q[IDX_FILE_SEL_PTR[SLOT_AW:0]];

   genvar g;
   generate
      for (g = 0; g < SFR_STORE; g++) begin : g_slot
         localparam logic [DW-1:0] RST =
            (g == int'(IDX_CORE_FLAGS_WORD)) ? FLAGS_RESET : SFR_RESET;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_q[g] <= RST;
            end else if (we && present && index == g) begin
               mem_q[g] <= wdata;
            end
         end
      end
   endgenerate
endmodule

// ### logic/bdmd_decoder.sv
// Banked data memory decoder: core file port plus APB register access.
`timescale 1ns/1ps

module bdmd_decoder #(
   parameter int APB_AW = 12
) (
   input  wire logic                            pclk,        // Core clock, 40 MHz.
   input  wire logic                            presetn,     // Asynchronous reset, active low.
   input  wire logic [bdmd_pkg::FILE_AW-1:0]    core_addr,   // File address from instruction.
   input  wire logic                            core_rd,     // Core read strobe.
   input  wire logic                            core_wr,     // Core write strobe.
   input  wire logic [bdmd_pkg::DW-1:0]         core_wdata,  // Core write data.
   output logic      [bdmd_pkg::DW-1:0]         core_rdata,  // Core read data, registered.
   output logic                                 bank_select, // Current bank select bit.
   output logic      [bdmd_pkg::DW-1:0]         file_sel_ptr, // Current file select pointer.
   input  wire logic                            psel,        // APB select.
   input  wire logic                            penable,     // APB enable.
   input  wire logic                            pwrite,      // APB direction.
   input  wire logic [APB_AW-1:0]               paddr,       // APB byte address.
   input  wire logic [31:0]                     pwdata,      // APB write data.
   output logic      [31:0]                     prdata,      // APB read data, registered.
   output logic                                 pready,      // APB ready.
   output logic                                 pslverr      // APB error for unmapped word.
);
   import bdmd_pkg::*;

   logic [DW-1:0]      flags;
   logic [DW-1:0]      fsp;
   logic [DM_AW-1:0]   dir_addr;
   logic [DM_AW-1:0]   apb_index;
   logic               apb_mapped;
   logic               core_sel;
   logic               apb_access;
   logic               apb_go;
   logic               acc_wr;
   logic [DW-1:0]      acc_wdata;
   logic [DM_AW-1:0]   req_addr;
   logic               req_indirect;
   logic [DM_AW-1:0]   eff_addr;
   logic               eff_indirect;
   logic               sfr_region;
   logic               gpr_region;
   logic [GPR_AW-1:0]  gpr_index;
   logic [DW-1:0]      gpr_rdata;
   logic [DW-1:0]      sfr_rdata;
   logic               sfr_present;
   logic [DW-1:0]      acc_rdata;
   logic               sfr_we;
   logic               gpr_we;
   logic [DW-1:0]      core_rdata_q;
   logic [DW-1:0]      core_rdata_d;
   logic [DW-1:0]      prdata_q;
   logic [DW-1:0]      prdata_d;
   logic               ack_q;
   logic               ack_d;
   logic               err_q;
   logic               err_d;

   // Direct access address formed from the live bank select bit.
   assign bank_select  = flags[FLAGS_BANK_SELECT];
   assign dir_addr     = {bank_select, core_addr};
   assign file_sel_ptr = fsp;

   // APB word index is the full data memory address, so both banks are visible.
   assign apb_index  = paddr[APB_IDX_LSB +: DM_AW];
   assign apb_mapped = (paddr >> (APB_IDX_LSB + DM_AW)) == '0;
   assign apb_access = psel & penable;

   // The core never stalls, so it owns the memory whenever it strobes.
   assign core_sel  = core_rd | core_wr;
   assign apb_go    = apb_access & ~ack_q & ~core_sel;
   assign acc_wr    = core_sel ? core_wr : (apb_go & pwrite & apb_mapped);
   assign acc_wdata = core_sel ? core_wdata : pwdata[DW-1:0];
   assign req_addr  = core_sel ? dir_addr : apb_index;

   // Indirect port in either bank carries no storage and redirects to the pointer.
   assign req_indirect = req_addr[FILE_AW-1:0] == IND_OFFSET;
   assign eff_addr     = req_indirect ? fsp : req_addr;
   // A pointer aimed at the indirect port itself reaches nothing.
   assign eff_indirect = eff_addr[FILE_AW-1:0] == IND_OFFSET;

   // Region decode on the offset within a bank.
   assign sfr_region = (eff_addr[FILE_AW-1:0] < SFR_LIMIT) & ~eff_indirect;
   assign gpr_region = (eff_addr[FILE_AW-1:0] >= GPR_FIRST) &
                       (eff_addr[FILE_AW-1:0] <= GPR_LAST);
   // The bank bit is dropped, so both banks land on the same entry.
   assign gpr_index  = GPR_AW'(eff_addr[FILE_AW-1:0] - GPR_FIRST);

   // Stores happen only where storage exists; anything else is dropped quietly.
   assign sfr_we = acc_wr & sfr_region;
   assign gpr_we = acc_wr & gpr_region;

   bdmd_sfr_store u_sfr (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (sfr_we),
      .bank    (eff_addr[DM_AW-1]),
      .slot    (eff_addr[SLOT_AW-1:0]),
      .wdata   (acc_wdata),
      .rdata   (sfr_rdata),
      .present (sfr_present),
      .flags   (flags),
      .fsp     (fsp)
   );

   bdmd_gpr_ram #(
      .DEPTH (GPR_DEPTH),
      .AW    (GPR_AW)
   ) u_gpr (
      .pclk  (pclk),
      .we    (gpr_we),
      .addr  (gpr_index),
      .wdata (acc_wdata),
      .rdata (gpr_rdata)
   );

   // Read mux: everything outside the two stores returns zero.
   assign acc_rdata = (sfr_region & sfr_present) ? sfr_rdata :
                      gpr_region                  ? gpr_rdata : READ_ZERO;

   // Core read data is captured at the strobe edge and held until the next read.
   assign core_rdata_d = core_rd ? acc_rdata : core_rdata_q;

   // APB acts once in its first free access cycle and answers on the next one.
   assign ack_d    = apb_access & ~ack_q & ~core_sel;
   assign err_d    = apb_go ? ~apb_mapped : err_q;
   assign prdata_d = (apb_go & ~pwrite) ? (apb_mapped ? acc_rdata : READ_ZERO) : prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rdata_q <= READ_ZERO;
         prdata_q     <= READ_ZERO;
         ack_q        <= 1'b0;
         err_q        <= 1'b0;
      end else begin
         core_rdata_q <= core_rdata_d;
         prdata_q     <= prdata_d;
         ack_q        <= ack_d;
         err_q        <= err_d;
      end
   end

   // Reserved flag bits are stored as written; keeping them zero is software's duty.
   assign core_rdata = core_rdata_q;
   assign prdata     = {{(32-DW){1'b0}}, prdata_q};
   assign pready     = ack_q;
   assign pslverr    = ack_q & err_q;
endmodule

// ### sim/bdmd_decoder_asserts.sv
// Port assertions for the banked data memory decoder.
`timescale 1ns/1ps
module bdmd_decoder_asserts (
   input wire logic                          pclk,         // Clock.
   input wire logic                          presetn,      // Reset.
   input wire logic [bdmd_pkg::FILE_AW-1:0]  core_addr,    // File address.
   input wire logic                          core_rd,      // Read strobe.
   input wire logic                          core_wr,      // Write strobe.
   input wire logic [bdmd_pkg::DW-1:0]       core_wdata,   // Write data.
   input wire logic [bdmd_pkg::DW-1:0]       core_rdata,   // Read data.
   input wire logic                          bank_select,  // Bank bit.
   input wire logic [bdmd_pkg::DW-1:0]       file_sel_ptr, // Pointer.
   input wire logic                          psel          // APB select.
);
   import bdmd_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wd5 = core_wdata[5];
   sequence s_gpr_wr;
      core_wr && core_addr >= GPR_FIRST && core_addr <= GPR_LAST;
   endsequence
   // The core leaves one idle cycle between a write and the next strobe.
   sequence s_same_rd;
      core_rd && core_addr == $past(core_addr, 2);
   endsequence
   a_gpr_shared: assert property (
      s_gpr_wr ##1 !core_wr ##1 s_same_rd |=> core_rdata == $past(core_wdata, 3))
      else $error("Shared RAM did not return the written byte.");
   a_unimpl_read_zero: assert property (
      core_rd && core_addr >= 7'h60 |=> core_rdata == 8'h00)
      else $error("Absent location read non-zero.");
   a_ind_null_zero: assert property (
      core_rd && core_addr == IND_OFFSET && file_sel_ptr[6:0] == 7'h00
      |=> core_rdata == 8'h00)
      else $error("Indirect port through itself read non-zero.");
   a_bank_follow: assert property (
      core_wr && core_addr == 7'h03 |=> bank_select == $past(wd5))
      else $error("Bank bit does not follow the flags write.");
   a_ptr_write: assert property (
      core_wr && core_addr == 7'h04 |=> file_sel_ptr == $past(core_wdata))
      else $error("Pointer not written directly.");
   a_ind_redirect: assert property (
      core_wr && core_addr == 7'h00 && file_sel_ptr == 8'h04
      |=> file_sel_ptr == $past(core_wdata))
      else $error("Indirect write missed the pointed location.");
   a_ignore_unimpl: assert property (
      core_wr && core_addr >= 7'h60
      |=> $stable(file_sel_ptr) && $stable(bank_select))
      else $error("Write to absent location changed state.");
   a_sfr_hold: assert property (
      !core_wr && !psel |=> $stable(file_sel_ptr))
      else $error("Pointer changed with no write.");
endmodule
bind bdmd_decoder bdmd_decoder_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .core_addr(core_addr), .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata),
   .core_rdata(core_rdata), .bank_select(bank_select), .file_sel_ptr(file_sel_ptr),
   .psel(psel));

// ### sim/bdmd_core_model.sv
// Behavioural processor core issuing file accesses.
`timescale 1ns/1ps
module bdmd_core_model (
   input  wire logic                         pclk,       // Clock.
   input  wire logic [bdmd_pkg::DW-1:0]      core_rdata, // Read data.
   output logic      [bdmd_pkg::FILE_AW-1:0] core_addr,  // File address.
   output logic                              core_rd,    // Read strobe.
   output logic                              core_wr,    // Write strobe.
   output logic      [bdmd_pkg::DW-1:0]      core_wdata  // Write data.
);
   import bdmd_pkg::*;
   initial begin
      core_addr  = 7'h00;
      core_rd    = 1'b0;
      core_wr    = 1'b0;
      core_wdata = 8'h00;
   end
   task automatic put(input logic [FILE_AW-1:0] a, input logic [DW-1:0] d);
      @(posedge pclk);
      core_addr  <= a;
      core_wdata <= (a == 7'h03) ? (d & 8'h3F) : d;
      core_wr    <= 1'b1;
      @(posedge pclk);
      core_wr    <= 1'b0;
      // Stale data is inverted so nothing can lean on it after the strobe.
      core_wdata <= ~d;
      // Returning off the edge lets callers see the stored result settled.
      @(negedge pclk);
   endtask
   task automatic get(input logic [FILE_AW-1:0] a, output logic [DW-1:0] d);
      @(posedge pclk);
      core_addr <= a;
      core_rd   <= 1'b1;
      @(posedge pclk);
      core_rd   <= 1'b0;
      @(negedge pclk);
      d = core_rdata;
   endtask
endmodule

// ### sim/banked_data_memory_decoder_test.sv
// Self-checking bench for the banked data memory decoder.
`timescale 1ns/1ps
module banked_data_memory_decoder_test;
   import bdmd_pkg::*;
   logic pclk, presetn, core_rd, core_wr, bank_select, psel, penable, pwrite, pready, pslverr;
   logic [6:0] core_addr;
   logic [7:0] core_wdata, core_rdata, file_sel_ptr, d;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic err;
   int err_count, n_tests, cycles, i;
   bdmd_decoder dut (.pclk(pclk), .presetn(presetn), .core_addr(core_addr),
      .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata), .core_rdata(core_rdata),
      .bank_select(bank_select), .file_sel_ptr(file_sel_ptr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   bdmd_core_model core (.pclk(pclk), .core_rdata(core_rdata), .core_addr(core_addr),
      .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h00C, 32'h0);
      check("flags reset", rd, {24'h0, FLAGS_RESET});
      check("bank reset", bank_select, 32'h0);
      $display("Test reset done");
      for (i = 0; i < 64; i++) core.put(7'h20 + 7'(i), 8'(i) ^ 8'hC3);
      core.put(7'h03, 8'h38);
      check("bank one", bank_select, 32'h1);
      for (i = 0; i < 64; i++) begin
         core.get(7'h20 + 7'(i), d);
         check("gpr", d, 8'(i) ^ 8'hC3);
      end
      core.put(7'h30, 8'h9E);
      core.get(7'h30, d);
      check("gpr back", d, 8'h9E);
      apb(1'b0, 12'h294, 32'h0);
      check("gpr apb", rd, 32'hC6);
      $display("Test shared ram done");
      core.put(7'h15, 8'h5A);
      core.get(7'h15, d);
      check("bank1 slot", d, 8'h5A);
      core.put(7'h03, 8'h18);
      core.get(7'h15, d);
      check("bank0 slot", d, 8'h00);
      core.put(7'h70, 8'hFF);
      core.get(7'h70, d);
      check("absent", d, 8'h00);
      core.get(7'h7F, d);
      check("top", d, 8'h00);
      $display("Test decode done");
      core.put(7'h04, 8'hA1);
      core.get(7'h00, d);
      check("ind read", d, 8'hC2);
      core.put(7'h00, 8'h77);
      core.get(7'h21, d);
      check("ind write", d, 8'h77);
      core.put(7'h04, 8'h80);
      core.get(7'h00, d);
      check("ind self", d, 8'h00);
      core.put(7'h04, 8'h04);
      core.put(7'h00, 8'h84);
      check("ptr via ind", file_sel_ptr, 32'h84);
      $display("Test indirect done");
      apb(1'b1, 12'h00C, 32'h38);
      check("apb bank", bank_select, 32'h1);
      apb(1'b1, 12'hC0C, 32'hFF);
      check("unmapped err", err, 32'h1);
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h00C, 32'h0);
      check("flags hold", rd, 32'h38);
      $display("Test apb done");
      // Mid-run reset: slots return to their reset values, the RAM keeps its bytes.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("ptr reset", file_sel_ptr, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, 12'h00C, 32'h0);
      check("flags again", rd, {24'h0, FLAGS_RESET});
      check("bank again", bank_select, 32'h0);
      core.get(7'h20, d);
      check("ram kept", d, 8'hC3);
      $display("Test reset again done");
      tally_and_finish();
   end
endmodule
